/* rtl/desc_pkg.sv */
package desc_pkg;

   // Descriptor selector codes seen on the request port
   localparam logic [1:0] SEL_BULK_OUT = 2'h0;
   localparam logic [1:0] SEL_INTR     = 2'h1;
   localparam logic [1:0] SEL_BOS      = 2'h2;
   localparam logic [1:0] SEL_RSVD     = 2'h3;

   // Byte offsets inside a descriptor
   localparam logic [2:0] OFS_LENGTH   = 3'h0;
   localparam logic [2:0] OFS_TYPE     = 3'h1;
   localparam logic [2:0] OFS_BURST    = 3'h2;
   localparam logic [2:0] OFS_ATTR     = 3'h3;
   localparam logic [2:0] OFS_BPI_LO   = 3'h4;
   localparam logic [2:0] OFS_BPI_HI   = 3'h5;
   localparam logic [2:0] OFS_TLEN_LO  = 3'h2;
   localparam logic [2:0] OFS_TLEN_HI  = 3'h3;
   localparam logic [2:0] OFS_NUM_CAPS = 3'h4;

   // Companion descriptor constants
   localparam logic [7:0]  COMP_LENGTH       = 8'h06;
   localparam logic [7:0]  COMP_TYPE         = 8'h30;
   localparam logic [3:0]  BULK_BURST_DEF    = 4'h3;
   localparam logic [7:0]  BULK_ATTR         = 8'h00;
   localparam logic [15:0] BULK_BPI          = 16'h0000;
   localparam logic [7:0]  INTR_BURST        = 8'h00;
   localparam logic [7:0]  INTR_ATTR         = 8'h00;
   localparam logic [15:0] INTR_BPI          = 16'h0004;

   // Object-store header constants and loadable defaults
   localparam logic [7:0]  BOS_LENGTH        = 8'h05;
   localparam logic [7:0]  BOS_TYPE          = 8'h0F;
   localparam logic [15:0] BOS_TOTAL_DEF     = 16'h0016;
   localparam logic [7:0]  BOS_NUM_CAPS_DEF  = 8'h02;

   // USB 2.0 extension capability attributes default
   localparam logic [31:0] USB2_ATTR_DEF     = 32'h0000_0006;

   localparam logic [7:0]  BYTE_ZERO         = 8'h00;

endpackage

/* rtl/desc_rd_if.sv */
`timescale 1ns/1ns
interface desc_rd_if;
   logic        rd_en;
   logic [1:0]  sel;
   logic [2:0]  idx;
   logic [3:0]  burst;
   logic [15:0] total_len;
   logic [7:0]  num_caps;
   logic [7:0]  rd_data;

   modport reader (output rd_en, sel, idx, burst, total_len, num_caps, input rd_data);
   modport rom    (input rd_en, sel, idx, burst, total_len, num_caps, output rd_data);
endinterface

/* rtl/desc_byte_rom.sv */
`timescale 1ns/1ns
module desc_byte_rom (
   input  wire logic clk,
   input  wire logic rst,
   desc_rd_if.rom    rd
);

   typedef struct packed {
      logic [7:0] rd_data;
   } rom_state_t;

   rom_state_t q;
   rom_state_t d;

   function automatic logic [7:0] desc_byte(input logic [1:0]  sel,
                                           input logic [2:0]  idx,
                                           input logic [3:0]  burst,
                                           input logic [15:0] tlen,
                                           input logic [7:0]  ncaps);
      logic [7:0] b;
      b = desc_pkg::BYTE_ZERO;
      if (sel == desc_pkg::SEL_BULK_OUT) begin
         unique case (idx)
            desc_pkg::OFS_LENGTH: b = desc_pkg::COMP_LENGTH;
            desc_pkg::OFS_TYPE:   b = desc_pkg::COMP_TYPE;
            desc_pkg::OFS_BURST:  b = {4'h0, burst};
            desc_pkg::OFS_ATTR:   b = desc_pkg::BULK_ATTR;
            desc_pkg::OFS_BPI_LO: b = desc_pkg::BULK_BPI[7:0];
            desc_pkg::OFS_BPI_HI: b = desc_pkg::BULK_BPI[15:8];
            default:              b = desc_pkg::BYTE_ZERO;
         endcase
      end else if (sel == desc_pkg::SEL_INTR) begin
         unique case (idx)
            desc_pkg::OFS_LENGTH: b = desc_pkg::COMP_LENGTH;
            desc_pkg::OFS_TYPE:   b = desc_pkg::COMP_TYPE;
            desc_pkg::OFS_BURST:  b = desc_pkg::INTR_BURST;
            desc_pkg::OFS_ATTR:   b = desc_pkg::INTR_ATTR;
            desc_pkg::OFS_BPI_LO: b = desc_pkg::INTR_BPI[7:0];
            desc_pkg::OFS_BPI_HI: b = desc_pkg::INTR_BPI[15:8];
            default:              b = desc_pkg::BYTE_ZERO;
         endcase
      end else if (sel == desc_pkg::SEL_BOS) begin
         unique case (idx)
            desc_pkg::OFS_LENGTH:   b = desc_pkg::BOS_LENGTH;
            desc_pkg::OFS_TYPE:     b = desc_pkg::BOS_TYPE;
            desc_pkg::OFS_TLEN_LO:  b = tlen[7:0];
            desc_pkg::OFS_TLEN_HI:  b = tlen[15:8];
            desc_pkg::OFS_NUM_CAPS: b = ncaps;
            default:                b = desc_pkg::BYTE_ZERO;
         endcase
      end
      return b;
   endfunction

   always_comb begin
      d = q;
      if (rd.rd_en) begin
         d.rd_data = desc_byte(rd.sel, rd.idx, rd.burst, rd.total_len, rd.num_caps);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rd.rd_data = q.rd_data;

endmodule

/* rtl/desc_source.sv */
`timescale 1ns/1ns
module desc_source (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        req_valid,
   input  wire logic [1:0]  req_sel,
   input  wire logic [15:0] req_len,
   input  wire logic        burst_override_en,
   input  wire logic [3:0]  bulk_out_burst_override,
   input  wire logic        nv_load,
   input  wire logic        nv_valid,
   input  wire logic [15:0] nv_total_len,
   input  wire logic [7:0]  nv_num_caps,
   input  wire logic [31:0] nv_usb2_attr,
   output logic             tx_valid,
   output logic [7:0]       tx_data,
   output logic             tx_last,
   output logic             tx_done,
   output logic             busy,
   output logic             req_stall,
   output logic [31:0]      usb2_ext_attr
);

   typedef enum logic [1:0] {
      S_IDLE = 2'b01,
      S_SEND = 2'b10
   } st_t;

   typedef struct packed {
      st_t         st;
      logic [1:0]  sel;
      logic [2:0]  rd_idx;
      logic [2:0]  cnt;
      logic [2:0]  tx_pos;
      logic        tx_valid;
      logic [7:0]  tx_data;
      logic        tx_last;
      logic        tx_done;
      logic        req_stall;
      logic [15:0] total_len;
      logic [7:0]  num_caps;
      logic [31:0] usb2_attr;
   } src_state_t;

   src_state_t q;
   src_state_t d;
   logic [2:0] n_bytes;

   desc_rd_if rd ();

   desc_byte_rom u_rom (
      .clk (clk),
      .rst (rst),
      .rd  (rd.rom)
   );

   function automatic logic [2:0] full_len(input logic [1:0] sel);
      return (sel == desc_pkg::SEL_BOS) ? desc_pkg::BOS_LENGTH[2:0]
                                        : desc_pkg::COMP_LENGTH[2:0];
   endfunction

   // Bytes to send: the shorter of the request and the descriptor
   function automatic logic [2:0] clip_len(input logic [15:0] want, input logic [2:0] full);
      return (want < {13'h0, full}) ? want[2:0] : full;
   endfunction

   always_comb begin
      d           = q;
      d.tx_valid  = 1'b0;
      d.tx_last   = 1'b0;
      d.tx_done   = 1'b0;
      d.req_stall = 1'b0;
      n_bytes     = clip_len(req_len, full_len(req_sel));
      rd.rd_en    = 1'b0;
      rd.sel      = q.sel;
      rd.idx      = q.rd_idx;
      // Bulk-out burst never looks at the store, only at the override input when enabled, else BULK_BURST_DEF
      rd.burst     = burst_override_en ? bulk_out_burst_override
                                       : desc_pkg::BULK_BURST_DEF;
      rd.total_len = q.total_len;
      rd.num_caps  = q.num_caps;
      if (nv_load) begin
         if (nv_valid) begin
            d.total_len = nv_total_len;
            d.num_caps  = nv_num_caps;
            d.usb2_attr = nv_usb2_attr;
         end else begin
            d.total_len = desc_pkg::BOS_TOTAL_DEF;
            d.num_caps  = desc_pkg::BOS_NUM_CAPS_DEF;
            d.usb2_attr = desc_pkg::USB2_ATTR_DEF;
         end
      end
      unique case (q.st)
         S_IDLE: begin
            rd.sel = req_sel;
            if (req_valid) begin
               if (req_sel == desc_pkg::SEL_RSVD) begin
                  d.req_stall = 1'b1;
               end else begin
                  d.sel = req_sel;
                  d.cnt = n_bytes;
                  if (n_bytes == 3'h0) begin
                     d.tx_done = 1'b1;
                  end else begin
                     rd.rd_en  = 1'b1;
                     rd.idx    = 3'h0;
                     d.rd_idx  = 3'h1;
                     d.st      = S_SEND;
                  end
               end
            end
         end
         S_SEND: begin
            d.tx_valid = 1'b1;
            d.tx_data  = rd.rd_data;
            d.tx_pos   = q.rd_idx - 3'h1;
            if (q.rd_idx == q.cnt) begin
               d.tx_last = 1'b1;
               d.tx_done = 1'b1;
               d.st      = S_IDLE;
            end else begin
               rd.rd_en = 1'b1;
               d.rd_idx = q.rd_idx + 3'h1;
            end
         end
         default: begin
            d.st = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '{st: S_IDLE, total_len: desc_pkg::BOS_TOTAL_DEF,
                num_caps: desc_pkg::BOS_NUM_CAPS_DEF,
                usb2_attr: desc_pkg::USB2_ATTR_DEF, default: '0};
      end else begin
         q <= d;
      end
   end

   assign tx_valid      = q.tx_valid;
   assign tx_data       = q.tx_data;
   assign tx_last       = q.tx_last;
   assign tx_done       = q.tx_done;
   assign busy          = q.st[1];
   assign req_stall     = q.req_stall;
   assign usb2_ext_attr = q.usb2_attr;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   comp_len_byte_a: assert property (
      tx_valid && q.sel != desc_pkg::SEL_BOS && q.tx_pos == 3'h0 |-> tx_data == 8'h06)
      else $error("companion length byte wrong");

   comp_type_byte_a: assert property (
      tx_valid && q.sel != desc_pkg::SEL_BOS && q.tx_pos == 3'h1 |-> tx_data == 8'h30)
      else $error("companion type byte wrong");

   bulk_burst_a: assert property (
      tx_valid && q.sel == desc_pkg::SEL_BULK_OUT && q.tx_pos == 3'h2
      |-> tx_data == ($past(burst_override_en, 2) ? {4'h0, $past(bulk_out_burst_override, 2)}
                                                  : 8'h03))
      else $error("bulk-out burst byte wrong");

   bulk_tail_zero_a: assert property (
      tx_valid && q.sel == desc_pkg::SEL_BULK_OUT && q.tx_pos > 3'h2 |-> tx_data == 8'h00)
      else $error("bulk-out tail byte not zero");

   intr_fields_a: assert property (
      tx_valid && q.sel == desc_pkg::SEL_INTR && q.tx_pos > 3'h1
      |-> tx_data == ((q.tx_pos == 3'h4) ? 8'h04 : 8'h00))
      else $error("interrupt companion field wrong");

   bos_header_a: assert property (
      tx_valid && q.sel == desc_pkg::SEL_BOS && q.tx_pos < 3'h2
      |-> tx_data == ((q.tx_pos == 3'h0) ? 8'h05 : 8'h0F))
      else $error("object-store header byte wrong");

   bos_total_len_a: assert property (
      tx_valid && q.sel == desc_pkg::SEL_BOS && q.tx_pos == 3'h2
      |-> tx_data == $past(q.total_len[7:0], 2))
      else $error("object-store total length low byte wrong");

   nv_load_take_a: assert property (
      nv_load && nv_valid |=> q.num_caps == $past(nv_num_caps) &&
                              q.total_len == $past(nv_total_len))
      else $error("store load not taken");

   nv_default_a: assert property (
      nv_load && !nv_valid |=> q.total_len == 16'h0016 && q.num_caps == 8'h02 &&
                               usb2_ext_attr == 32'h0000_0006)
      else $error("defaults not restored without store");

   usb2_attr_a: assert property (
      nv_load && nv_valid |=> usb2_ext_attr == $past(nv_usb2_attr))
      else $error("USB 2.0 extension attributes not loaded");

   short_req_a: assert property (
      !busy && req_valid && req_sel != desc_pkg::SEL_RSVD && req_len == 16'h0002
      |=> ##1 tx_valid ##1 (tx_valid && tx_last) ##1 !tx_valid)
      else $error("short request length not honoured");

   bulk_full_c: cover property (
      tx_last && q.sel == desc_pkg::SEL_BULK_OUT && q.tx_pos == 3'h5);
   intr_full_c: cover property (
      tx_last && q.sel == desc_pkg::SEL_INTR && q.tx_pos == 3'h5);
   bos_full_c: cover property (
      tx_last && q.sel == desc_pkg::SEL_BOS && q.tx_pos == 3'h4);
   override_c: cover property (
      tx_valid && q.tx_pos == 3'h2 && q.sel == desc_pkg::SEL_BULK_OUT
      && $past(burst_override_en, 2));

endmodule

/* tb/host_model.sv */
`timescale 1ns/1ns
module host_model (
   input  wire logic        clk,
   input  wire logic        busy,
   input  wire logic        tx_valid,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_last,
   input  wire logic        tx_done,
   input  wire logic        req_stall,
   output logic             req_valid,
   output logic [1:0]       req_sel,
   output logic [15:0]      req_len
);
   logic [7:0] rx_q[$];
   // Byte count at the final-byte marker, busy cycles seen, and stall answer
   int         last_at;
   int         busy_cnt;
   logic       stall_seen;

   initial begin
      req_valid = 1'b0;
      req_sel   = 2'h0;
      req_len   = 16'h0000;
   end

   // One descriptor read after gap idle cycles; the answer lands in rx_q
   task automatic get_desc(input logic [1:0] sel, input logic [15:0] len, input int gap);
      int t;
      rx_q.delete();
      last_at    = 0;
      busy_cnt   = 0;
      stall_seen = 1'b0;
      repeat (gap) @(posedge clk);
      @(posedge clk);
      req_valid <= 1'b1;
      req_sel   <= sel;
      req_len   <= len;
      // Held until an edge sees the block idle
      for (t = 0; t < 40; t++) begin
         @(posedge clk);
         if (busy === 1'b0) break;
      end
      req_valid <= 1'b0;
      req_sel   <= ~sel;
      req_len   <= ~len;
      for (t = 0; t < 40; t++) begin
         @(posedge clk);
         if (busy === 1'b1) busy_cnt++;
         if (tx_valid === 1'b1) rx_q.push_back(tx_data);
         if (tx_last === 1'b1) last_at = rx_q.size();
         if (req_stall === 1'b1) stall_seen = 1'b1;
         if (tx_done === 1'b1 || req_stall === 1'b1) break;
      end
   endtask
endmodule

/* tb/tb_ss_companion_bos_descriptor_rom.sv */
`timescale 1ns/1ns
module tb_ss_companion_bos_descriptor_rom;
   logic        clk;
   logic        rst;
   logic        burst_override_en;
   logic [3:0]  bulk_out_burst_override;
   logic        nv_load;
   logic        nv_valid;
   logic [15:0] nv_total_len;
   logic [7:0]  nv_num_caps;
   logic [31:0] nv_usb2_attr;
   logic        req_valid;
   logic [1:0]  req_sel;
   logic [15:0] req_len;
   logic        tx_valid;
   logic [7:0]  tx_data;
   logic        tx_last;
   logic        tx_done;
   logic        busy;
   logic        req_stall;
   logic [31:0] usb2_ext_attr;
   int          fail_count;
   int          cmp_count;
   int          cycle_count;

   desc_source desc_source_inst (
      .clk                     (clk),
      .rst                     (rst),
      .req_valid               (req_valid),
      .req_sel                 (req_sel),
      .req_len                 (req_len),
      .burst_override_en       (burst_override_en),
      .bulk_out_burst_override (bulk_out_burst_override),
      .nv_load                 (nv_load),
      .nv_valid                (nv_valid),
      .nv_total_len            (nv_total_len),
      .nv_num_caps             (nv_num_caps),
      .nv_usb2_attr            (nv_usb2_attr),
      .tx_valid                (tx_valid),
      .tx_data                 (tx_data),
      .tx_last                 (tx_last),
      .tx_done                 (tx_done),
      .busy                    (busy),
      .req_stall               (req_stall),
      .usb2_ext_attr           (usb2_ext_attr)
   );

   host_model host_model_inst (
      .clk       (clk),
      .busy      (busy),
      .tx_valid  (tx_valid),
      .tx_data   (tx_data),
      .tx_last   (tx_last),
      .tx_done   (tx_done),
      .req_stall (req_stall),
      .req_valid (req_valid),
      .req_sel   (req_sel),
      .req_len   (req_len)
   );

   always #2 clk = ~clk;

   task automatic complete_run();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycle_count++;
      if (cycle_count == 5000) begin
         fail_count++;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Byte 0 of exp sits in the top byte
   task automatic read_desc(input logic [1:0] sel, input logic [15:0] len,
                            input logic [47:0] exp, input int n, input int gap);
      host_model_inst.get_desc(sel, len, gap);
      check(32'(host_model_inst.rx_q.size()), 32'(n));
      check(32'(host_model_inst.last_at), 32'(n));
      check(32'(host_model_inst.busy_cnt), 32'(n));
      check({31'h0, host_model_inst.stall_seen}, 32'h0);
      for (int k = 0; k < n; k++) begin
         check({24'h0, host_model_inst.rx_q[k]}, {24'h0, exp[47-8*k -: 8]});
      end
   endtask

   task automatic nv_store(input logic v, input logic [15:0] tl, input logic [7:0] nc,
                           input logic [31:0] at);
      @(posedge clk);
      nv_load      <= 1'b1;
      nv_valid     <= v;
      nv_total_len <= tl;
      nv_num_caps  <= nc;
      nv_usb2_attr <= at;
      @(posedge clk);
      nv_load      <= 1'b0;
      nv_total_len <= ~tl;
      nv_num_caps  <= ~nc;
      nv_usb2_attr <= ~at;
      @(posedge clk);
   endtask

   task automatic test_defaults();
      check(usb2_ext_attr, 32'h0000_0006);
      read_desc(desc_pkg::SEL_BOS, 16'h0005, 48'h050F_1600_0200, 5, 0);
   endtask

   task automatic test_companions_with_store();
      nv_store(1'b1, 16'hABCD, 8'h07, 32'h0000_001E);
      read_desc(desc_pkg::SEL_BULK_OUT, 16'h0006, 48'h0630_0300_0000, 6, 0);
      read_desc(desc_pkg::SEL_INTR, 16'h0040, 48'h0630_0000_0400, 6, 3);
   endtask

   task automatic test_override();
      logic [3:0] vals[3] = '{4'h0, 4'hF, 4'h9};
      foreach (vals[j]) begin
         @(posedge clk);
         burst_override_en       <= 1'b1;
         bulk_out_burst_override <= vals[j];
         read_desc(desc_pkg::SEL_BULK_OUT, 16'h0006, {16'h0630, 4'h0, vals[j], 24'h0}, 6, 1);
      end
      @(posedge clk);
      burst_override_en       <= 1'b0;
      bulk_out_burst_override <= 4'hC;
      read_desc(desc_pkg::SEL_BULK_OUT, 16'h0006, 48'h0630_0300_0000, 6, 0);
   endtask

   task automatic test_store_load();
      nv_store(1'b1, 16'h1234, 8'h03, 32'h0000_F21E);
      check(usb2_ext_attr, 32'h0000_F21E);
      read_desc(desc_pkg::SEL_BOS, 16'h0100, 48'h050F_3412_0300, 5, 2);
      read_desc(desc_pkg::SEL_BOS, 16'h0003, 48'h050F_3400_0000, 3, 0);
      read_desc(desc_pkg::SEL_BOS, 16'h0000, 48'h0, 0, 0);
      nv_store(1'b0, 16'h5555, 8'h09, 32'h0000_0018);
      check(usb2_ext_attr, 32'h0000_0006);
      read_desc(desc_pkg::SEL_BOS, 16'h0005, 48'h050F_1600_0200, 5, 0);
   endtask

   task automatic test_reserved();
      host_model_inst.get_desc(desc_pkg::SEL_RSVD, 16'h0006, 0);
      check(32'(host_model_inst.rx_q.size()), 32'h0);
      check({31'h0, host_model_inst.stall_seen}, 32'h1);
      check(32'(host_model_inst.busy_cnt), 32'h0);
      read_desc(desc_pkg::SEL_INTR, 16'h0002, 48'h0630_0000_0000, 2, 0);
   endtask

   initial begin
      clk                     = 1'b0;
      rst                     = 1'b1;
      burst_override_en       = 1'b0;
      bulk_out_burst_override = 4'h0;
      nv_load                 = 1'b0;
      nv_valid                = 1'b0;
      nv_total_len            = 16'h0000;
      nv_num_caps             = 8'h00;
      nv_usb2_attr            = 32'h0000_0000;
      fail_count              = 0;
      cmp_count               = 0;
      cycle_count             = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      test_defaults();
      test_companions_with_store();
      test_override();
      test_store_load();
      test_reserved();
      complete_run();
   end
endmodule
